// [escb_map.vh]
// Register indices, field positions, reset values and timing constants of the extension bank
`ifndef ESCB_MAP_VH
`define ESCB_MAP_VH
// ----------------------------------------------------------------------
// Indices
// ----------------------------------------------------------------------
`define ESCB_IDX_UNLOCK      8'h05
`define ESCB_IDX_PWR         8'h11
`define ESCB_IDX_FIRST       8'h14
`define ESCB_IDX_LAST        8'h2F
`define ESCB_IDX_CC0R        8'h14
`define ESCB_IDX_CC0G        8'h15
`define ESCB_IDX_CC0B        8'h16
`define ESCB_IDX_CC1R        8'h17
`define ESCB_IDX_CC1G        8'h18
`define ESCB_IDX_CC1B        8'h19
`define ESCB_IDX_HPOS_LO     8'h1A
`define ESCB_IDX_HPOS_HI     8'h1B
`define ESCB_IDX_HPRESET     8'h1C
`define ESCB_IDX_VPOS_LO     8'h1D
`define ESCB_IDX_VPOS_HI     8'h1E
`define ESCB_IDX_VPRESET     8'h1F
`define ESCB_IDX_APB_LO      8'h20
`define ESCB_IDX_APB_HI      8'h21
`define ESCB_IDX_TIMERS      8'h22
`define ESCB_IDX_MISC2       8'h23
`define ESCB_IDX_ENG0        8'h26
`define ESCB_IDX_ENG1        8'h27
`define ESCB_IDX_MCLK0       8'h28
`define ESCB_IDX_MCLK1       8'h29
`define ESCB_IDX_VCLK0       8'h2A
`define ESCB_IDX_VCLK1       8'h2B
`define ESCB_IDX_CQ0         8'h2C
`define ESCB_IDX_CQ1         8'h2D
`define ESCB_IDX_CQ2         8'h2E
`define ESCB_IDX_REPAIR      8'h2F
// ----------------------------------------------------------------------
// Unlock codes and read-back
// ----------------------------------------------------------------------
`define ESCB_UNLOCK_CODE     8'h86
`define ESCB_ID_UNLOCKED     8'hA1
`define ESCB_ID_LOCKED       8'h21
// ----------------------------------------------------------------------
// Power control bit positions and register reset value
// ----------------------------------------------------------------------
`define ESCB_PWR_SUSPEND     7
`define ESCB_PWR_STANDBY     6
`define ESCB_PWR_ACT_MEM     5
`define ESCB_PWR_ACT_KBD     4
`define ESCB_PWR_REPAIR      2
`define ESCB_PWR_DATA        1
`define ESCB_PWR_CLK         0
`define ESCB_RESET_VAL       8'h00
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define ESCB_CLK_PERIOD_PS   5000
`define ESCB_TIMER_STEP_S    120
// Two minutes of 200 MHz clock cycles per timer step
`define ESCB_TIMER_STEP_CYCLES 40'h59682F000
`endif

// [escb_bank.v]
// Extension control register bank behind an index/data port pair
`timescale 1ns/10ps
`include "escb_map.vh"

module escb_bank #(
    parameter [39:0] TIMER_STEP_CYCLES = `ESCB_TIMER_STEP_CYCLES
) (
    // Clock and reset
    input  wire        MCLK_I,
    input  wire        RESET_I,
    // Index/data host port
    input  wire        IDX_WR_I,
    input  wire        DATA_WR_I,
    input  wire        DATA_RD_I,
    input  wire [7:0]  WDATA_I,
    output reg  [7:0]  RDATA_O,
    // Monitor data channel pins
    input  wire        MON_CLK_I,
    output reg         MON_CLK_O,
    output reg         MON_CLK_OE_O,
    input  wire        MON_DATA_I,
    output reg         MON_DATA_O,
    output reg         MON_DATA_OE_O,
    // Activity events
    input  wire        VMEM_ACCESS_I,
    input  wire        KBD_CURSOR_ACT_I,
    // Power state
    output reg         SUSPEND_O,
    output reg         STANDBY_O,
    // Cursor
    output reg  [35:0] CURSOR_COLORS_O,
    output reg  [10:0] CURSOR_HSTART_O,
    output reg  [10:0] CURSOR_VSTART_O,
    output reg  [3:0]  CURSOR_PATTERN_O,
    output reg  [5:0]  CURSOR_HPRESET_O,
    output reg  [5:0]  CURSOR_VPRESET_O,
    // Aperture
    output reg  [12:0] APERTURE_BASE_O,
    output reg  [1:0]  APERTURE_SIZE_O,
    // Memory controller
    output reg  [1:0]  DRAM_DELAY_O,
    output reg  [2:0]  DRAM_CYCLE_CLKS_O,
    output reg         ROW_STROBE_SWAP_O,
    output reg  [7:0]  ROW_REPAIR_ENTRY_O,
    output reg         ROW_REPAIR_EN_O,
    // Command queue and engine
    output reg  [1:0]  CQ_LENGTH_O,
    output reg         CQ_SUSPEND_O,
    output reg  [23:0] CQ_BASE_O,
    output reg         CQ_ENGINE_EN_O,
    output reg         ENGINE_PROG_EN_O,
    output reg  [1:0]  SCREEN_WIDTH_O,
    output reg         SCREEN_WIDTH_BAD_O,
    // Clock synthesizers
    output reg  [15:0] MCLK_SYNTH_O,
    output reg  [15:0] PIXEL_CLOCK_SYNTH_O
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    localparam NREG = 28;
    reg  [7:0]  bank_q [0:NREG-1];
    reg  [7:0]  idx_q;
    reg         unlocked_q;
    reg  [7:0]  pwr_q;
    reg         clk_s1_q;
    reg         clk_s2_q;
    reg         dat_s1_q;
    reg         dat_s2_q;
    reg         mem_s1_q;
    reg         mem_s2_q;
    reg         kbd_s1_q;
    reg         kbd_s2_q;
    reg  [39:0] step_q;
    reg  [4:0]  sby_cnt_q;
    reg  [4:0]  sus_cnt_q;
    reg         sby_idle_q;
    reg         sus_idle_q;
    reg  [7:0]  rd_d;

    wire in_bank  = (idx_q >= `ESCB_IDX_FIRST) && (idx_q <= `ESCB_IDX_LAST);
    wire [4:0] slot = idx_q[4:0] - 5'h14;
    wire bank_wr  = DATA_WR_I && unlocked_q && in_bank;
    wire pwr_wr   = DATA_WR_I && unlocked_q && (idx_q == `ESCB_IDX_PWR);

    // Fetch a stored register by index
    function [7:0] reg_at;
        input [7:0] idx;
        reg   [4:0] s;
        begin
            s = idx[4:0] - 5'h14;
            reg_at = bank_q[s];
        end
    endfunction

    // Field layout: reserved bits are never stored
    function [7:0] wmask;
        input [4:0] s;
        begin
            if (s <= 5'd5)
                wmask = 8'h3F;
            else if (s == 5'd7)
                wmask = 8'h07;
            else if (s == 5'd8 || s == 5'd11)
                wmask = 8'h3F;
            else if (s == 5'd10)
                wmask = 8'hF7;
            else if (s == 5'd13)
                wmask = 8'h7F;
            else if (s == 5'd15)
                wmask = 8'h0F;
            else if (s == 5'd18)
                wmask = 8'h7F;
            else
                wmask = 8'hFF;
        end
    endfunction

    // ------------------------------------------------------------------
    // Host port and registers
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NREG; g = g + 1) begin : g_reg
            always @(posedge MCLK_I) begin
                if (RESET_I)
                    bank_q[g] <= `ESCB_RESET_VAL;
                else if (bank_wr && slot == g)
                    bank_q[g] <= WDATA_I & wmask(slot);
            end
        end
    endgenerate

    always @(posedge MCLK_I) begin
        if (RESET_I) begin
            idx_q      <= 8'h00;
            unlocked_q <= 1'b0;
            pwr_q      <= `ESCB_RESET_VAL;
        end else begin
            if (IDX_WR_I)
                idx_q <= WDATA_I;
            if (DATA_WR_I && idx_q == `ESCB_IDX_UNLOCK)
                unlocked_q <= (WDATA_I == `ESCB_UNLOCK_CODE);
            if (pwr_wr)
                pwr_q <= WDATA_I & 8'hF7;
        end
    end

    // Line levels come from the synchronised pins, not the stored bits
    always @* begin
        rd_d = 8'h00;
        if (idx_q == `ESCB_IDX_UNLOCK)
            rd_d = unlocked_q ? `ESCB_ID_UNLOCKED : `ESCB_ID_LOCKED;
        else if (!unlocked_q)
            rd_d = 8'h00;
        else if (idx_q == `ESCB_IDX_PWR)
            rd_d = {pwr_q[7:2], dat_s2_q, clk_s2_q};
        else if (in_bank)
            rd_d = reg_at(idx_q);
    end

    always @(posedge MCLK_I) begin
        if (RESET_I)
            RDATA_O <= 8'h00;
        else if (DATA_RD_I)
            RDATA_O <= rd_d;
    end

    // ------------------------------------------------------------------
    // Monitor channel pins
    // ------------------------------------------------------------------
    // Open drain: a written 1 releases the line so the far end may pull it
    always @(posedge MCLK_I) begin
        if (RESET_I) begin
            clk_s1_q      <= 1'b0;
            clk_s2_q      <= 1'b0;
            dat_s1_q      <= 1'b0;
            dat_s2_q      <= 1'b0;
            MON_CLK_O     <= 1'b0;
            MON_CLK_OE_O  <= 1'b1;
            MON_DATA_O    <= 1'b0;
            MON_DATA_OE_O <= 1'b1;
        end else begin
            clk_s1_q      <= MON_CLK_I;
            clk_s2_q      <= clk_s1_q;
            dat_s1_q      <= MON_DATA_I;
            dat_s2_q      <= dat_s1_q;
            MON_CLK_O     <= 1'b0;
            MON_CLK_OE_O  <= ~pwr_q[`ESCB_PWR_CLK];
            MON_DATA_O    <= 1'b0;
            MON_DATA_OE_O <= ~pwr_q[`ESCB_PWR_DATA];
        end
    end

    // ------------------------------------------------------------------
    // Inactivity timers
    // ------------------------------------------------------------------
    wire wake = (pwr_q[`ESCB_PWR_ACT_MEM] && mem_s2_q) ||
                (pwr_q[`ESCB_PWR_ACT_KBD] && kbd_s2_q);
    wire [3:0] sus_lim = bank_q[14][7:4];
    wire [3:0] sby_lim = bank_q[14][3:0];
    wire       tick    = (step_q == TIMER_STEP_CYCLES - 40'd1);

    // Counters saturate at 31, above any limit, so expiry holds until wake
    always @(posedge MCLK_I) begin
        if (RESET_I) begin
            mem_s1_q   <= 1'b0;
            mem_s2_q   <= 1'b0;
            kbd_s1_q   <= 1'b0;
            kbd_s2_q   <= 1'b0;
            step_q     <= 40'd0;
            sby_cnt_q  <= 5'd0;
            sus_cnt_q  <= 5'd0;
            sby_idle_q <= 1'b0;
            sus_idle_q <= 1'b0;
        end else begin
            mem_s1_q <= VMEM_ACCESS_I;
            mem_s2_q <= mem_s1_q;
            kbd_s1_q <= KBD_CURSOR_ACT_I;
            kbd_s2_q <= kbd_s1_q;
            if (wake) begin
                step_q     <= 40'd0;
                sby_cnt_q  <= 5'd0;
                sus_cnt_q  <= 5'd0;
                sby_idle_q <= 1'b0;
                sus_idle_q <= 1'b0;
            end else begin
                step_q <= tick ? 40'd0 : step_q + 40'd1;
                if (tick && sby_cnt_q != 5'h1F)
                    sby_cnt_q <= sby_cnt_q + 5'd1;
                if (tick && sus_cnt_q != 5'h1F)
                    sus_cnt_q <= sus_cnt_q + 5'd1;
                sby_idle_q <= (sby_lim != 4'd0) && (sby_cnt_q >= {1'b0, sby_lim});
                sus_idle_q <= (sus_lim != 4'd0) && (sus_cnt_q >= {1'b0, sus_lim});
            end
        end
    end

    // ------------------------------------------------------------------
    // Power state outputs
    // ------------------------------------------------------------------
    // Force bits and timer expiry are ORed so software can override idle
    always @(posedge MCLK_I) begin
        if (RESET_I) begin
            SUSPEND_O           <= 1'b0;
            STANDBY_O           <= 1'b0;
        end else begin
            SUSPEND_O <= pwr_q[`ESCB_PWR_SUSPEND] || sus_idle_q;
            STANDBY_O <= pwr_q[`ESCB_PWR_STANDBY] || sby_idle_q;
        end
    end

    // ------------------------------------------------------------------
    // Cursor outputs
    // ------------------------------------------------------------------
    // Split fields are assembled live; a half-written pair shows until its other half is written
    always @(posedge MCLK_I) begin
        if (RESET_I) begin
            CURSOR_COLORS_O     <= 36'h000000000;
            CURSOR_HSTART_O     <= 11'h000;
            CURSOR_VSTART_O     <= 11'h000;
            CURSOR_PATTERN_O    <= 4'h0;
            CURSOR_HPRESET_O    <= 6'h00;
            CURSOR_VPRESET_O    <= 6'h00;
        end else begin
            CURSOR_COLORS_O <= {bank_q[5][5:0], bank_q[4][5:0], bank_q[3][5:0],
                                bank_q[2][5:0], bank_q[1][5:0], bank_q[0][5:0]};
            CURSOR_HSTART_O  <= {bank_q[7][2:0], bank_q[6]};
            CURSOR_VSTART_O  <= {bank_q[10][2:0], bank_q[9]};
            CURSOR_PATTERN_O <= bank_q[10][7:4];
            CURSOR_HPRESET_O <= bank_q[8][5:0];
            CURSOR_VPRESET_O <= bank_q[11][5:0];
        end
    end

    // ------------------------------------------------------------------
    // Aperture outputs
    // ------------------------------------------------------------------
    always @(posedge MCLK_I) begin
        if (RESET_I) begin
            APERTURE_BASE_O     <= 13'h0000;
            APERTURE_SIZE_O     <= 2'h0;
        end else begin
            APERTURE_BASE_O  <= {bank_q[13][4:0], bank_q[12]};
            APERTURE_SIZE_O  <= bank_q[13][6:5];
        end
    end

    // ------------------------------------------------------------------
    // Memory controller outputs
    // ------------------------------------------------------------------
    // Reset leaves the slow, safe seven-clock DRAM cycle
    always @(posedge MCLK_I) begin
        if (RESET_I) begin
            DRAM_DELAY_O        <= 2'h0;
            DRAM_CYCLE_CLKS_O   <= 3'h7;
            ROW_STROBE_SWAP_O   <= 1'b0;
            ROW_REPAIR_ENTRY_O  <= 8'h00;
            ROW_REPAIR_EN_O     <= 1'b0;
        end else begin
            DRAM_DELAY_O     <= bank_q[15][1:0];
            DRAM_CYCLE_CLKS_O <= bank_q[18][1] ? 3'h6 : 3'h7;
            ROW_STROBE_SWAP_O <= bank_q[18][0];
            ROW_REPAIR_ENTRY_O <= bank_q[27];
            ROW_REPAIR_EN_O  <= pwr_q[`ESCB_PWR_REPAIR];
        end
    end

    // ------------------------------------------------------------------
    // Command queue and engine outputs
    // ------------------------------------------------------------------
    always @(posedge MCLK_I) begin
        if (RESET_I) begin
            CQ_LENGTH_O         <= 2'h0;
            CQ_SUSPEND_O        <= 1'b0;
            CQ_BASE_O           <= 24'h000000;
            CQ_ENGINE_EN_O      <= 1'b0;
            ENGINE_PROG_EN_O    <= 1'b0;
            SCREEN_WIDTH_O      <= 2'h0;
            SCREEN_WIDTH_BAD_O  <= 1'b0;
        end else begin
            CQ_LENGTH_O      <= bank_q[18][3:2];
            CQ_SUSPEND_O     <= bank_q[18][4];
            CQ_BASE_O        <= {bank_q[26], bank_q[25], bank_q[24]};
            CQ_ENGINE_EN_O   <= bank_q[19][7];
            ENGINE_PROG_EN_O <= bank_q[19][6];
            SCREEN_WIDTH_O   <= bank_q[19][5:4];
            SCREEN_WIDTH_BAD_O <= (bank_q[19][5:4] == 2'h3);
        end
    end

    // ------------------------------------------------------------------
    // Clock synthesizer outputs
    // ------------------------------------------------------------------
    // Raw codes pass through; the analogue side adds the plus-one offsets
    always @(posedge MCLK_I) begin
        if (RESET_I) begin
            MCLK_SYNTH_O        <= 16'h0000;
            PIXEL_CLOCK_SYNTH_O <= 16'h0000;
        end else begin
            MCLK_SYNTH_O     <= {bank_q[21], bank_q[20]};
            PIXEL_CLOCK_SYNTH_O <= {bank_q[23], bank_q[22]};
        end
    end

endmodule // escb_bank

// [escb_bank_chk.sv]
// Concurrent checks on the extension register bank ports
`timescale 1ns/10ps
`include "escb_map.vh"
// ----------------------------------------------------------------------
// Checker
// ----------------------------------------------------------------------
module escb_chk (
    input wire        MCLK_I,
    input wire        RESET_I,
    input wire        IDX_WR_I,
    input wire        DATA_WR_I,
    input wire        DATA_RD_I,
    input wire [7:0]  WDATA_I,
    input wire [7:0]  RDATA_O,
    input wire        MON_CLK_OE_O,
    input wire        MON_DATA_OE_O,
    input wire        SUSPEND_O,
    input wire        STANDBY_O,
    input wire [35:0] CURSOR_COLORS_O,
    input wire [12:0] APERTURE_BASE_O,
    input wire [2:0]  DRAM_CYCLE_CLKS_O,
    input wire        CQ_ENGINE_EN_O,
    input wire [1:0]  SCREEN_WIDTH_O,
    input wire        SCREEN_WIDTH_BAD_O
);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RESET_I);
    // Own copy of index and lock so checks need no internal probes
    reg  [7:0] idx_q;
    reg        unl_q;
    wire       wr_ok = DATA_WR_I && unl_q;
    always @(posedge MCLK_I) begin
        if (RESET_I) begin
            idx_q <= 8'h00;
            unl_q <= 1'b0;
        end else begin
            if (IDX_WR_I)
                idx_q <= WDATA_I;
            if (DATA_WR_I && idx_q == `ESCB_IDX_UNLOCK)
                unl_q <= WDATA_I == `ESCB_UNLOCK_CODE;
        end
    end
    property p_id;
        DATA_RD_I && idx_q == `ESCB_IDX_UNLOCK |=>
            RDATA_O == ($past(unl_q) ? `ESCB_ID_UNLOCKED : `ESCB_ID_LOCKED);
    endproperty
    a_id: assert property (p_id) else $error("id read wrong");
    property p_lock;
        DATA_RD_I && !unl_q && idx_q >= 8'h14 && idx_q <= 8'h2F |=> RDATA_O == 8'h00;
    endproperty
    a_lock: assert property (p_lock) else $error("locked read not zero");
    property p_susp;
        wr_ok && idx_q == `ESCB_IDX_PWR && WDATA_I[7] |=> ##1 SUSPEND_O;
    endproperty
    a_susp: assert property (p_susp) else $error("suspend not forced");
    property p_stby;
        wr_ok && idx_q == `ESCB_IDX_PWR && WDATA_I[6] |=> ##1 STANDBY_O;
    endproperty
    a_stby: assert property (p_stby) else $error("standby not forced");
    property p_oe;
        wr_ok && idx_q == `ESCB_IDX_PWR |=> ##1 MON_DATA_OE_O == !$past(WDATA_I[1], 2)
            && MON_CLK_OE_O == !$past(WDATA_I[0], 2);
    endproperty
    a_oe: assert property (p_oe) else $error("line drive wrong");
    property p_cyc;
        wr_ok && idx_q == `ESCB_IDX_ENG0 |=> ##1
            DRAM_CYCLE_CLKS_O == ($past(WDATA_I[1], 2) ? 3'h6 : 3'h7);
    endproperty
    a_cyc: assert property (p_cyc) else $error("dram cycle wrong");
    property p_eng;
        wr_ok && idx_q == `ESCB_IDX_ENG1 |=> ##1 CQ_ENGINE_EN_O == $past(WDATA_I[7], 2);
    endproperty
    a_eng: assert property (p_eng) else $error("engine enable wrong");
    property p_apb;
        wr_ok && idx_q == `ESCB_IDX_APB_LO |=> ##1 APERTURE_BASE_O[7:0] == $past(WDATA_I, 2);
    endproperty
    a_apb: assert property (p_apb) else $error("aperture base wrong");
    property p_col;
        wr_ok && idx_q == `ESCB_IDX_CC0R |=> ##1 CURSOR_COLORS_O[5:0] == $past(WDATA_I[5:0], 2);
    endproperty
    a_col: assert property (p_col) else $error("cursor colour wrong");
    property p_bad;
        SCREEN_WIDTH_BAD_O == (SCREEN_WIDTH_O == 2'h3);
    endproperty
    a_bad: assert property (p_bad) else $error("width flag wrong");
endmodule // escb_chk
bind escb_bank escb_chk u_chk (.MCLK_I, .RESET_I, .IDX_WR_I, .DATA_WR_I, .DATA_RD_I,
    .WDATA_I, .RDATA_O, .MON_CLK_OE_O, .MON_DATA_OE_O, .SUSPEND_O, .STANDBY_O,
    .CURSOR_COLORS_O, .APERTURE_BASE_O, .DRAM_CYCLE_CLKS_O, .CQ_ENGINE_EN_O,
    .SCREEN_WIDTH_O, .SCREEN_WIDTH_BAD_O);

// [escb_bank_tb.sv]
// Self-checking bench for the extension register bank
`timescale 1ns/10ps
`include "escb_map.vh"
// ----------------------------------------------------------------------
// Bench
// ----------------------------------------------------------------------
module testbench;
    reg         MCLK_I = 1'b0, RESET_I = 1'b1, IDX_WR_I = 1'b0, DATA_WR_I = 1'b0;
    reg         DATA_RD_I = 1'b0, VMEM_ACCESS_I = 1'b0, KBD_CURSOR_ACT_I = 1'b0;
    reg  [7:0]  WDATA_I = 8'h00;
    reg         clk_ext = 1'b1, dat_ext = 1'b1;
    wire [7:0]  RDATA_O, ROW_REPAIR_ENTRY_O;
    wire        MON_CLK_O, MON_CLK_OE_O, MON_DATA_O, MON_DATA_OE_O, SUSPEND_O, STANDBY_O;
    wire        ROW_STROBE_SWAP_O, ROW_REPAIR_EN_O, CQ_SUSPEND_O, CQ_ENGINE_EN_O;
    wire        ENGINE_PROG_EN_O, SCREEN_WIDTH_BAD_O;
    wire [35:0] CURSOR_COLORS_O;
    wire [10:0] CURSOR_HSTART_O, CURSOR_VSTART_O;
    wire [3:0]  CURSOR_PATTERN_O;
    wire [5:0]  CURSOR_HPRESET_O, CURSOR_VPRESET_O;
    wire [12:0] APERTURE_BASE_O;
    wire [1:0]  APERTURE_SIZE_O, DRAM_DELAY_O, CQ_LENGTH_O, SCREEN_WIDTH_O;
    wire [2:0]  DRAM_CYCLE_CLKS_O;
    wire [23:0] CQ_BASE_O;
    wire [15:0] MCLK_SYNTH_O, PIXEL_CLOCK_SYNTH_O;
    // Pulled-up lines: low if the bank or the monitor side pulls them
    wire        MON_CLK_I = (MON_CLK_OE_O ? MON_CLK_O : 1'b1) & clk_ext;
    wire        MON_DATA_I = (MON_DATA_OE_O ? MON_DATA_O : 1'b1) & dat_ext;
    integer     n_fail = 0, check_count = 0, i;
    always #2.5 MCLK_I = ~MCLK_I;
    // Short timer step keeps two-minute counts to tens of cycles
    escb_bank #(.TIMER_STEP_CYCLES(40'h0A)) u_dut (.MCLK_I, .RESET_I, .IDX_WR_I, .DATA_WR_I,
        .DATA_RD_I, .WDATA_I, .RDATA_O, .MON_CLK_I, .MON_CLK_O, .MON_CLK_OE_O, .MON_DATA_I,
        .MON_DATA_O, .MON_DATA_OE_O, .VMEM_ACCESS_I, .KBD_CURSOR_ACT_I, .SUSPEND_O,
        .STANDBY_O, .CURSOR_COLORS_O, .CURSOR_HSTART_O, .CURSOR_VSTART_O, .CURSOR_PATTERN_O,
        .CURSOR_HPRESET_O, .CURSOR_VPRESET_O, .APERTURE_BASE_O, .APERTURE_SIZE_O,
        .DRAM_DELAY_O, .DRAM_CYCLE_CLKS_O, .ROW_STROBE_SWAP_O, .ROW_REPAIR_ENTRY_O,
        .ROW_REPAIR_EN_O, .CQ_LENGTH_O, .CQ_SUSPEND_O, .CQ_BASE_O, .CQ_ENGINE_EN_O,
        .ENGINE_PROG_EN_O, .SCREEN_WIDTH_O, .SCREEN_WIDTH_BAD_O, .MCLK_SYNTH_O,
        .PIXEL_CLOCK_SYNTH_O);
    task chk(input [63:0] seen, input [63:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
            end
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge MCLK_I);
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(negedge MCLK_I) IDX_WR_I = 1'b1;
            WDATA_I = a;
            @(negedge MCLK_I) IDX_WR_I = 1'b0;
            DATA_WR_I = 1'b1;
            WDATA_I = d;
            @(negedge MCLK_I) DATA_WR_I = 1'b0;
        end
    endtask
    task rc(input [7:0] a, input [7:0] exp);
        begin
            @(negedge MCLK_I) IDX_WR_I = 1'b1;
            WDATA_I = a;
            @(negedge MCLK_I) IDX_WR_I = 1'b0;
            DATA_RD_I = 1'b1;
            @(negedge MCLK_I) DATA_RD_I = 1'b0;
            chk(RDATA_O, exp);
        end
    endtask
    // Readable bits per index; reserved bits must read zero
    function [7:0] msk(input [7:0] a);
        case (a)
            8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1C, 8'h1F: msk = 8'h3F;
            8'h1B: msk = 8'h07;
            8'h1E: msk = 8'hF7;
            8'h21, 8'h26: msk = 8'h7F;
            8'h23: msk = 8'h0F;
            default: msk = 8'hFF;
        endcase
    endfunction
    task wrap_up;
        begin
            $display("checks=%0d mismatches=%0d", check_count, n_fail);
            if (n_fail == 0 && check_count > 0) $display("Result: passed");
            else $display("Result: failed");
            $finish;
        end
    endtask
    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        cyc(3);
        RESET_I = 1'b0;
        chk({DRAM_CYCLE_CLKS_O, MON_CLK_OE_O, MON_DATA_OE_O, SUSPEND_O}, 6'h3E);
        rc(`ESCB_IDX_UNLOCK, `ESCB_ID_LOCKED);
        wr(8'h14, 8'h3F);
        wr(`ESCB_IDX_UNLOCK, `ESCB_UNLOCK_CODE);
        rc(8'h14, 8'h00);
        rc(`ESCB_IDX_UNLOCK, `ESCB_ID_UNLOCKED);
        cyc(200);
        chk({SUSPEND_O, STANDBY_O}, 2'h0);
        for (i = 8'h14; i <= 8'h2F; i = i + 1) wr(i[7:0], 8'hFF);
        for (i = 8'h14; i <= 8'h2F; i = i + 1) rc(i[7:0], msk(i[7:0]));
        chk({CURSOR_COLORS_O, CURSOR_HSTART_O, CURSOR_VSTART_O}, {36'hFFFFFFFFF, 22'h3FFFFF});
        chk({CQ_ENGINE_EN_O, ENGINE_PROG_EN_O, SCREEN_WIDTH_BAD_O, CQ_SUSPEND_O}, 4'hF);
        for (i = 8'h14; i <= 8'h2F; i = i + 1) wr(i[7:0], i[7:0]);
        cyc(2);
        chk({CURSOR_COLORS_O, CURSOR_HSTART_O, CURSOR_VSTART_O, CURSOR_PATTERN_O},
            {6'h19, 6'h18, 6'h17, 6'h16, 6'h15, 6'h14, 11'h31A, 11'h61D, 4'h1});
        chk({CURSOR_HPRESET_O, CURSOR_VPRESET_O, APERTURE_BASE_O, APERTURE_SIZE_O,
            DRAM_DELAY_O}, {6'h1C, 6'h1F, 13'h0120, 2'h1, 2'h3});
        chk({DRAM_CYCLE_CLKS_O, CQ_LENGTH_O, CQ_SUSPEND_O, ROW_STROBE_SWAP_O, CQ_BASE_O},
            {3'h6, 2'h1, 2'h0, 24'h2E2D2C});
        chk({CQ_ENGINE_EN_O, ENGINE_PROG_EN_O, SCREEN_WIDTH_O, SCREEN_WIDTH_BAD_O,
            MCLK_SYNTH_O, PIXEL_CLOCK_SYNTH_O, ROW_REPAIR_ENTRY_O},
            {4'h2, 1'b0, 16'h2928, 16'h2B2A, 8'h2F});
        chk({SUSPEND_O, STANDBY_O}, 2'h3);
        VMEM_ACCESS_I = 1'b1;
        wr(`ESCB_IDX_PWR, 8'h20);
        cyc(4);
        chk({SUSPEND_O, STANDBY_O}, 2'h0);
        wr(`ESCB_IDX_TIMERS, 8'h30);
        VMEM_ACCESS_I = 1'b0;
        cyc(20);
        chk({SUSPEND_O, STANDBY_O}, 2'h0);
        cyc(20);
        chk({SUSPEND_O, STANDBY_O}, 2'h2);
        KBD_CURSOR_ACT_I = 1'b1;
        cyc(5);
        chk(SUSPEND_O, 1'b1);
        wr(`ESCB_IDX_PWR, 8'h10);
        cyc(4);
        chk(SUSPEND_O, 1'b0);
        wr(`ESCB_IDX_TIMERS, 8'h00);
        KBD_CURSOR_ACT_I = 1'b0;
        wr(`ESCB_IDX_PWR, 8'h80);
        cyc(1);
        chk({SUSPEND_O, STANDBY_O}, 2'h2);
        wr(`ESCB_IDX_PWR, 8'h40);
        cyc(1);
        chk({SUSPEND_O, STANDBY_O}, 2'h1);
        wr(`ESCB_IDX_PWR, 8'h0F);
        cyc(3);
        rc(`ESCB_IDX_PWR, 8'h07);
        dat_ext = 1'b0;
        cyc(3);
        rc(`ESCB_IDX_PWR, 8'h05);
        clk_ext = 1'b0;
        dat_ext = 1'b1;
        cyc(3);
        rc(`ESCB_IDX_PWR, 8'h06);
        clk_ext = 1'b1;
        chk({ROW_REPAIR_EN_O, STANDBY_O, MON_CLK_OE_O, MON_DATA_OE_O}, 4'h8);
        wr(`ESCB_IDX_PWR, 8'h00);
        cyc(1);
        chk({ROW_REPAIR_EN_O, MON_CLK_OE_O, MON_DATA_OE_O}, 3'h3);
        chk({MON_CLK_O, MON_DATA_O}, 2'h0);
        wr(`ESCB_IDX_UNLOCK, 8'h00);
        rc(`ESCB_IDX_UNLOCK, `ESCB_ID_LOCKED);
        wr(`ESCB_IDX_REPAIR, 8'h55);
        rc(`ESCB_IDX_REPAIR, 8'h00);
        chk(ROW_REPAIR_ENTRY_O, 8'h2F);
        wrap_up;
    end
    // Whole sequence needs about 580 cycles; allow just over five times that
    initial begin
        cyc(3000);
        n_fail = n_fail + 1;
        wrap_up;
    end
endmodule // testbench
